/* src/srpl_map.vh */
/*
 * srpl_map.vh: image byte offsets, load masks, reset values and
 * register word addresses of the serial ROM preload block.
 * Assumes it is included by bare name, definitions only.
 */
`ifndef SRPL_MAP_VH
`define SRPL_MAP_VH

// image byte offsets
`define SRPL_OF_SIG      7'h00
`define SRPL_OF_PCLS0    7'h04
`define SRPL_OF_PCLS2    7'h06
`define SRPL_OF_SSVID0   7'h07
`define SRPL_OF_SSVID1   7'h08
`define SRPL_OF_SSID0    7'h09
`define SRPL_OF_SSID1    7'h0A
`define SRPL_OF_PGNT     7'h0B
`define SRPL_OF_PLAT     7'h0C
`define SRPL_OF_SCLS0    7'h0D
`define SRPL_OF_SCLS2    7'h0F
`define SRPL_OF_SGNT     7'h10
`define SRPL_OF_SLAT     7'h11
`define SRPL_OF_DSM0     7'h12
`define SRPL_OF_DSIO1    7'h16
`define SRPL_OF_DSM2     7'h1A
`define SRPL_OF_DSM3     7'h1E
`define SRPL_OF_DSM3U    7'h22
`define SRPL_OF_XROM0    7'h26
`define SRPL_OF_XROM1    7'h27
`define SRPL_OF_USIO0    7'h28
`define SRPL_OF_USM1     7'h2C
`define SRPL_OF_CC0      7'h30
`define SRPL_OF_CC1      7'h32
`define SRPL_OF_ARB      7'h34
`define SRPL_OF_PSERR    7'h36
`define SRPL_OF_SSERR    7'h37
`define SRPL_OF_PM       7'h38
`define SRPL_OF_CAP0     7'h41
`define SRPL_OF_CAP1     7'h42
`define SRPL_OF_LAST     7'h42

// enable signature in byte zero
`define SRPL_SIG_MSB     7
`define SRPL_SIG_LSB     6
`define SRPL_SIG_VAL     2'h2

// per-byte load masks, a set bit is loaded
`define SRPL_MK_ALL      8'hFF
`define SRPL_MK_MEM_B0   8'h0E
`define SRPL_MK_MEM_B1   8'hF0
`define SRPL_MK_IO_B0    8'hCF
`define SRPL_MK_CC0_B1   8'hCF
`define SRPL_MK_ARB_B1   8'h03
`define SRPL_MK_SERR     8'h7F
`define SRPL_MK_CAP0     8'hFC

// expansion ROM setup bit positions
`define SRPL_XR_EN_BIT   24
`define SRPL_XR_EN_SRC   0
`define SRPL_XR_SZ_LSB   12
`define SRPL_XR_SZ_SRC   4
`define SRPL_XR_HI_LSB   16

// reset values
`define SRPL_RST_PCLASS  24'h068000
`define SRPL_RST_ZERO8   8'h00
`define SRPL_RST_ZERO16  16'h0000
`define SRPL_RST_ZERO24  24'h000000
`define SRPL_RST_ZERO32  32'h00000000

// register word addresses
`define SRPL_AW          5
`define SRPL_RA_CTRL     5'h00
`define SRPL_RA_STAT     5'h01
`define SRPL_RA_PCLASS   5'h02
`define SRPL_RA_SUBSYS   5'h03
`define SRPL_RA_PGL      5'h04
`define SRPL_RA_SCLASS   5'h05
`define SRPL_RA_SGL      5'h06
`define SRPL_RA_DSM0     5'h07
`define SRPL_RA_DSIO1    5'h08
`define SRPL_RA_DSM2     5'h09
`define SRPL_RA_DSM3     5'h0A
`define SRPL_RA_DSM3U    5'h0B
`define SRPL_RA_XROM     5'h0C
`define SRPL_RA_USIO0    5'h0D
`define SRPL_RA_USM1     5'h0E
`define SRPL_RA_CHIPCTL  5'h0F
`define SRPL_RA_ARB      5'h10
`define SRPL_RA_SERR     5'h11
`define SRPL_RA_PMLO     5'h12
`define SRPL_RA_PMHI     5'h13
`define SRPL_RA_CAP      5'h14

// restart control bit, PM data depth and index width
`define SRPL_CT_RESTART  0
`define SRPL_PM_DEPTH    8
`define SRPL_PM_IW       3

`endif

/* src/srpl_buf2.v */
/*
 * srpl_buf2.v: two-entry byte buffer with valid and ready on both sides.
 * Assumes one clock, an active-low asynchronous reset and a clock enable.
 */
`default_nettype none

module srpl_buf2 (
    // clock and reset
    input  wire       i_clk_sys,
    input  wire       i_rst_b,
    input  wire       i_clk_en,
    input  wire       i_flush,
    // filling side
    input  wire       i_in_valid,
    input  wire [7:0] i_in_data,
    output reg        o_in_ready,
    // draining side
    output wire       o_out_valid,
    output wire [7:0] o_out_data,
    input  wire       i_out_ready
);
    reg  [7:0] mem [0:1];
    reg        wr_ptr;
    reg        rd_ptr;
    reg  [1:0] count;
    wire       push;
    wire       pop;
    reg  [1:0] next_count;

    assign o_out_valid = (count != 2'h0);
    assign o_out_data  = mem[rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always @* begin
        next_count = count;
        if (push && !pop)
            next_count = count + 2'h1;
        else if (pop && !push)
            next_count = count - 2'h1;
    end

    // ready is registered so the filling side sees a flop
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr     <= 1'b0;
            rd_ptr     <= 1'b0;
            count      <= 2'h0;
            o_in_ready <= 1'b1;
            mem[0]     <= 8'h00;
            mem[1]     <= 8'h00;
        end else if (i_clk_en) begin
            if (i_flush) begin
                wr_ptr     <= 1'b0;
                rd_ptr     <= 1'b0;
                count      <= 2'h0;
                o_in_ready <= 1'b1;
            end else begin
                if (push) begin
                    mem[wr_ptr] <= i_in_data;
                    wr_ptr      <= ~wr_ptr;
                end
                if (pop)
                    rd_ptr <= ~rd_ptr;
                count      <= next_count;
                o_in_ready <= (next_count != 2'h2);
            end
        end
    end
endmodule

`default_nettype wire

/* src/srpl_loader.v */
/*
 * srpl_loader.v: preloads configuration fields from a serial ROM byte
 * image after reset, and shows them to software over Avalon-MM.
 * Assumes a ROM reader that, after o_rom_start, streams image bytes from
 * offset zero in ascending order while o_rom_fetch is high.
 */
`include "srpl_map.vh"
`default_nettype none

module srpl_loader (
    // clock and reset
    input  wire        i_clk_sys,
    input  wire        i_rst_b,
    input  wire        i_clk_en,
    // serial ROM byte stream
    input  wire        i_rom_valid,
    input  wire [7:0]  i_rom_data,
    output reg         o_rom_ready,
    output reg         o_rom_start,
    output reg         o_rom_fetch,
    // load status
    output reg         o_cfg_valid,
    output reg         o_load_busy,
    // avalon-mm slave
    input  wire [4:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    output reg  [31:0] o_avs_readdata,
    output reg         o_avs_waitrequest
);
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_START = 2'h1;
    localparam [1:0] ST_LOAD  = 2'h2;
    localparam [1:0] ST_DONE  = 2'h3;

    reg  [1:0]  state;
    reg  [6:0]  ofs;
    reg         sig_ok;
    wire        buf_ready_w;
    wire        buf_valid;
    wire [7:0]  buf_data;
    wire        take;
    wire        restart;

    reg  [23:0] pclass;
    reg  [15:0] ssvid;
    reg  [15:0] ssid;
    reg  [7:0]  pgnt;
    reg  [7:0]  plat;
    reg  [23:0] sclass;
    reg  [7:0]  sgnt;
    reg  [7:0]  slat;
    reg  [31:0] dsm0;
    reg  [31:0] dsio1;
    reg  [31:0] dsm2;
    reg  [31:0] dsm3;
    reg  [31:0] dsm3u;
    reg  [31:0] xrom;
    reg  [31:0] usio0;
    reg  [31:0] usm1;
    reg  [15:0] cc0;
    reg  [15:0] cc1;
    reg  [15:0] arb;
    reg  [7:0]  pserr;
    reg  [7:0]  sserr;
    reg  [7:0]  pm_data [0:`SRPL_PM_DEPTH-1];
    reg  [7:0]  cap0;
    reg  [7:0]  cap1;
    reg  [31:0] next_rdata;
    integer     i;

    // only masked bits take the image; the rest keep their value
    function [7:0] merge;
        input [7:0] old;
        input [7:0] din;
        input [7:0] mask;
        begin
            merge = (old & ~mask) | (din & mask);
        end
    endfunction

    function [1:0] lane;
        input [6:0] o;
        input [6:0] base;
        begin
            lane = o[1:0] - base[1:0];
        end
    endfunction

    // two-entry buffer so a stalled loader drops no ROM byte
    srpl_buf2 u_buf (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_clk_en    (i_clk_en),
        .i_flush     (state == ST_START),
        .i_in_valid  (i_rom_valid && o_rom_fetch),
        .i_in_data   (i_rom_data),
        .o_in_ready  (buf_ready_w),
        .o_out_valid (buf_valid),
        .o_out_data  (buf_data),
        .i_out_ready (state == ST_LOAD)
    );

    assign take    = (state == ST_LOAD) && buf_valid;
    assign restart = i_avs_write && !o_avs_waitrequest &&
                     (i_avs_address == `SRPL_RA_CTRL) &&
                     i_avs_byteenable[0] &&
                     i_avs_writedata[`SRPL_CT_RESTART];

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state       <= ST_IDLE;
            ofs         <= 7'h00;
            sig_ok      <= 1'b0;
            o_rom_start <= 1'b0;
            o_rom_fetch <= 1'b0;
            o_rom_ready <= 1'b0;
            o_cfg_valid <= 1'b0;
            o_load_busy <= 1'b0;
        end else if (i_clk_en) begin
            o_rom_start <= 1'b0;
            o_rom_ready <= buf_ready_w && o_rom_fetch;
            case (state)
                ST_IDLE: begin
                    state       <= ST_START;
                    o_rom_start <= 1'b1;
                    o_load_busy <= 1'b1;
                    o_cfg_valid <= 1'b0;
                end
                ST_START: begin
                    state       <= ST_LOAD;
                    ofs         <= 7'h00;
                    o_rom_fetch <= 1'b1;
                    o_rom_ready <= 1'b1;
                end
                ST_LOAD: begin
                    if (take) begin
                        ofs <= ofs + 7'h01;
                        if (ofs == `SRPL_OF_SIG) begin
                            sig_ok <= (buf_data[`SRPL_SIG_MSB:`SRPL_SIG_LSB]
                                       == `SRPL_SIG_VAL);
                            if (buf_data[`SRPL_SIG_MSB:`SRPL_SIG_LSB]
                                != `SRPL_SIG_VAL) begin
                                state       <= ST_DONE;
                                o_rom_fetch <= 1'b0;
                                o_rom_ready <= 1'b0;
                            end
                        end
                        if (ofs == `SRPL_OF_LAST) begin
                            state       <= ST_DONE;
                            o_rom_fetch <= 1'b0;
                            o_rom_ready <= 1'b0;
                        end
                    end
                end
                ST_DONE: begin
                    o_load_busy <= 1'b0;
                    o_cfg_valid <= 1'b1;
                    if (restart) begin
                        state       <= ST_START;
                        o_rom_start <= 1'b1;
                        o_load_busy <= 1'b1;
                        o_cfg_valid <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // field loading; a byte outside any range is ignored
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pclass <= `SRPL_RST_PCLASS;
            ssvid  <= `SRPL_RST_ZERO16;
            ssid   <= `SRPL_RST_ZERO16;
            pgnt   <= `SRPL_RST_ZERO8;
            plat   <= `SRPL_RST_ZERO8;
            sclass <= `SRPL_RST_ZERO24;
            sgnt   <= `SRPL_RST_ZERO8;
            slat   <= `SRPL_RST_ZERO8;
            dsm0   <= `SRPL_RST_ZERO32;
            dsio1  <= `SRPL_RST_ZERO32;
            dsm2   <= `SRPL_RST_ZERO32;
            dsm3   <= `SRPL_RST_ZERO32;
            dsm3u  <= `SRPL_RST_ZERO32;
            xrom   <= `SRPL_RST_ZERO32;
            usio0  <= `SRPL_RST_ZERO32;
            usm1   <= `SRPL_RST_ZERO32;
            cc0    <= `SRPL_RST_ZERO16;
            cc1    <= `SRPL_RST_ZERO16;
            arb    <= `SRPL_RST_ZERO16;
            pserr  <= `SRPL_RST_ZERO8;
            sserr  <= `SRPL_RST_ZERO8;
            cap0   <= `SRPL_RST_ZERO8;
            cap1   <= `SRPL_RST_ZERO8;
            for (i = 0; i < `SRPL_PM_DEPTH; i = i + 1)
                pm_data[i] <= `SRPL_RST_ZERO8;
        end else if (i_clk_en && take && sig_ok) begin
            if (ofs >= `SRPL_OF_PCLS0 && ofs <= `SRPL_OF_PCLS2) begin
                pclass[8*(ofs-`SRPL_OF_PCLS0) +: 8] <= buf_data;
            end else if (ofs == `SRPL_OF_SSVID0) begin
                ssvid[7:0] <= buf_data;
            end else if (ofs == `SRPL_OF_SSVID1) begin
                ssvid[15:8] <= buf_data;
            end else if (ofs == `SRPL_OF_SSID0) begin
                ssid[7:0] <= buf_data;
            end else if (ofs == `SRPL_OF_SSID1) begin
                ssid[15:8] <= buf_data;
            end else if (ofs == `SRPL_OF_PGNT) begin
                pgnt <= buf_data;
            end else if (ofs == `SRPL_OF_PLAT) begin
                plat <= buf_data;
            end else if (ofs >= `SRPL_OF_SCLS0 && ofs <= `SRPL_OF_SCLS2) begin
                sclass[8*(ofs-`SRPL_OF_SCLS0) +: 8] <= buf_data;
            end else if (ofs == `SRPL_OF_SGNT) begin
                sgnt <= buf_data;
            end else if (ofs == `SRPL_OF_SLAT) begin
                slat <= buf_data;
            end else if (ofs >= `SRPL_OF_DSM0 && ofs < `SRPL_OF_DSIO1) begin
                case (lane(ofs, `SRPL_OF_DSM0))
                    2'h0: dsm0[7:0] <= merge(dsm0[7:0], buf_data,
                                             `SRPL_MK_MEM_B0);
                    2'h1: dsm0[15:8] <= merge(dsm0[15:8], buf_data,
                                              `SRPL_MK_MEM_B1);
                    2'h2: dsm0[23:16] <= buf_data;
                    default: dsm0[31:24] <= buf_data;
                endcase
            end else if (ofs >= `SRPL_OF_DSIO1 && ofs < `SRPL_OF_DSM2) begin
                case (lane(ofs, `SRPL_OF_DSIO1))
                    2'h0: dsio1[7:0] <= merge(dsio1[7:0], buf_data,
                                              `SRPL_MK_IO_B0);
                    2'h1: dsio1[15:8] <= buf_data;
                    2'h2: dsio1[23:16] <= buf_data;
                    default: dsio1[31:24] <= buf_data;
                endcase
            end else if (ofs >= `SRPL_OF_DSM2 && ofs < `SRPL_OF_DSM3) begin
                case (lane(ofs, `SRPL_OF_DSM2))
                    2'h0: dsm2[7:0] <= merge(dsm2[7:0], buf_data,
                                             `SRPL_MK_MEM_B0);
                    2'h1: dsm2[15:8] <= merge(dsm2[15:8], buf_data,
                                              `SRPL_MK_MEM_B1);
                    2'h2: dsm2[23:16] <= buf_data;
                    default: dsm2[31:24] <= buf_data;
                endcase
            end else if (ofs >= `SRPL_OF_DSM3 && ofs < `SRPL_OF_DSM3U) begin
                case (lane(ofs, `SRPL_OF_DSM3))
                    2'h0: dsm3[7:0] <= merge(dsm3[7:0], buf_data,
                                             `SRPL_MK_MEM_B0);
                    2'h1: dsm3[15:8] <= merge(dsm3[15:8], buf_data,
                                              `SRPL_MK_MEM_B1);
                    2'h2: dsm3[23:16] <= buf_data;
                    default: dsm3[31:24] <= buf_data;
                endcase
            end else if (ofs >= `SRPL_OF_DSM3U && ofs < `SRPL_OF_XROM0) begin
                dsm3u[8*lane(ofs, `SRPL_OF_DSM3U) +: 8] <= buf_data;
            end else if (ofs == `SRPL_OF_XROM0) begin
                xrom[`SRPL_XR_EN_BIT] <= buf_data[`SRPL_XR_EN_SRC];
                xrom[`SRPL_XR_SZ_LSB +: 4] <= buf_data[`SRPL_XR_SZ_SRC +: 4];
            end else if (ofs == `SRPL_OF_XROM1) begin
                xrom[`SRPL_XR_HI_LSB +: 8] <= buf_data;
            end else if (ofs >= `SRPL_OF_USIO0 && ofs < `SRPL_OF_USM1) begin
                case (lane(ofs, `SRPL_OF_USIO0))
                    2'h0: usio0[7:0] <= merge(usio0[7:0], buf_data,
                                              `SRPL_MK_IO_B0);
                    2'h1: usio0[15:8] <= buf_data;
                    2'h2: usio0[23:16] <= buf_data;
                    default: usio0[31:24] <= buf_data;
                endcase
            end else if (ofs >= `SRPL_OF_USM1 && ofs < `SRPL_OF_CC0) begin
                case (lane(ofs, `SRPL_OF_USM1))
                    2'h0: usm1[7:0] <= merge(usm1[7:0], buf_data,
                                             `SRPL_MK_MEM_B0);
                    2'h1: usm1[15:8] <= merge(usm1[15:8], buf_data,
                                              `SRPL_MK_MEM_B1);
                    2'h2: usm1[23:16] <= buf_data;
                    default: usm1[31:24] <= buf_data;
                endcase
            end else if (ofs == `SRPL_OF_CC0) begin
                cc0[7:0] <= buf_data;
            end else if (ofs == `SRPL_OF_CC0 + 7'h01) begin
                cc0[15:8] <= merge(cc0[15:8], buf_data, `SRPL_MK_CC0_B1);
            end else if (ofs == `SRPL_OF_CC1) begin
                cc1[7:0] <= buf_data;
            end else if (ofs == `SRPL_OF_CC1 + 7'h01) begin
                cc1[15:8] <= buf_data;
            end else if (ofs == `SRPL_OF_ARB) begin
                arb[7:0] <= buf_data;
            end else if (ofs == `SRPL_OF_ARB + 7'h01) begin
                arb[15:8] <= merge(arb[15:8], buf_data, `SRPL_MK_ARB_B1);
            end else if (ofs == `SRPL_OF_PSERR) begin
                pserr <= merge(pserr, buf_data, `SRPL_MK_SERR);
            end else if (ofs == `SRPL_OF_SSERR) begin
                sserr <= merge(sserr, buf_data, `SRPL_MK_SERR);
            end else if (ofs >= `SRPL_OF_PM &&
                         ofs < `SRPL_OF_PM + `SRPL_PM_DEPTH) begin
                pm_data[ofs[`SRPL_PM_IW-1:0]] <= buf_data;
            end else if (ofs == `SRPL_OF_CAP0) begin
                cap0 <= merge(cap0, buf_data, `SRPL_MK_CAP0);
            end else if (ofs == `SRPL_OF_CAP1) begin
                cap1 <= buf_data;
            end
        end
    end

    // read mux; unmapped words read as zero
    always @* begin
        next_rdata = 32'h00000000;
        case (i_avs_address)
            `SRPL_RA_STAT: next_rdata = {17'h00000, ofs, 5'h00,
                                         sig_ok, o_cfg_valid, o_load_busy};
            `SRPL_RA_PCLASS: next_rdata = {8'h00, pclass};
            `SRPL_RA_SUBSYS: next_rdata = {ssid, ssvid};
            `SRPL_RA_PGL: next_rdata = {16'h0000, plat, pgnt};
            `SRPL_RA_SCLASS: next_rdata = {8'h00, sclass};
            `SRPL_RA_SGL: next_rdata = {16'h0000, slat, sgnt};
            `SRPL_RA_DSM0: next_rdata = dsm0;
            `SRPL_RA_DSIO1: next_rdata = dsio1;
            `SRPL_RA_DSM2: next_rdata = dsm2;
            `SRPL_RA_DSM3: next_rdata = dsm3;
            `SRPL_RA_DSM3U: next_rdata = dsm3u;
            `SRPL_RA_XROM: next_rdata = xrom;
            `SRPL_RA_USIO0: next_rdata = usio0;
            `SRPL_RA_USM1: next_rdata = usm1;
            `SRPL_RA_CHIPCTL: next_rdata = {cc1, cc0};
            `SRPL_RA_ARB: next_rdata = {16'h0000, arb};
            `SRPL_RA_SERR: next_rdata = {16'h0000, sserr, pserr};
            `SRPL_RA_PMLO: next_rdata = {pm_data[3], pm_data[2],
                                         pm_data[1], pm_data[0]};
            `SRPL_RA_PMHI: next_rdata = {pm_data[7], pm_data[6],
                                         pm_data[5], pm_data[4]};
            `SRPL_RA_CAP: next_rdata = {16'h0000, cap1, cap0};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // fixed one wait state keeps the read mux off the bus timing path
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h00000000;
        end else if (i_clk_en) begin
            if (o_avs_waitrequest && (i_avs_read || i_avs_write)) begin
                o_avs_waitrequest <= 1'b0;
                o_avs_readdata    <= i_avs_read ? next_rdata : 32'h00000000;
            end else begin
                o_avs_waitrequest <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

/* bench/srpl_monitor.sv */
/* srpl_monitor: port assertions for srpl_loader.
   assumes a bind from the bench top, one clock domain. */
`default_nettype none
module srpl_monitor (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // bus and loader status
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic o_rom_ready,
    input wire logic o_rom_start,
    input wire logic o_rom_fetch,
    input wire logic o_cfg_valid,
    input wire logic o_load_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    bus_answer_a: assert property ((i_avs_read || i_avs_write)
        && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
    answer_pulse_a: assert property (!o_avs_waitrequest
        |=> o_avs_waitrequest) else $error("long answer");
    start_pulse_a: assert property (o_rom_start
        |=> !o_rom_start && o_rom_fetch) else $error("bad start");
    fetch_busy_a: assert property (o_rom_fetch |-> o_load_busy)
        else $error("fetch idle");
    done_idle_a: assert property (o_cfg_valid
        |-> !o_load_busy && !o_rom_fetch) else $error("valid busy");
    early_valid_a: assert property (o_rom_start
        |-> !o_cfg_valid ##1 !o_cfg_valid) else $error("early valid");
    valid_cause_a: assert property ($rose(o_cfg_valid)
        |-> $past(o_load_busy)) else $error("valid no load");
    load_end_a: assert property ($rose(o_load_busy)
        |-> ##[2:400] $rose(o_cfg_valid)) else $error("load hangs");
    ready_fetch_a: assert property (o_rom_ready
        |-> o_rom_fetch) else $error("ready without fetch");
    cover property ($rose(o_cfg_valid));
    cover property (i_avs_write && !o_avs_waitrequest);
    cover property (o_rom_start);
endmodule
`default_nettype wire

/* bench/srpl_rom_model.sv */
/* srpl_rom_model: serial ROM streaming its image from offset zero.
   assumes the bench fills img before each load. */
`default_nettype none
module srpl_rom_model (
    // clock and control
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic       i_start,
    input  wire logic       i_fetch,
    input  wire logic       i_ready,
    input  wire logic       i_stall,
    // byte stream
    output var  logic       o_valid,
    output wire logic [7:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] img [0:66];
    int         ofs;
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b || i_start) begin
            ofs <= 0;
            o_valid <= 1'b0;
        end else if (!o_valid || (i_ready && i_fetch)) begin
            ofs <= ofs + o_valid;
            o_valid <= i_fetch && !i_stall && ofs + o_valid < 67;
        end
    end
    // idle line toggles so a stale byte never looks valid
    assign o_data = o_valid ? img[ofs % 67] : ~img[ofs % 67];
endmodule
`default_nettype wire

/* bench/tb_serial_rom_register_preload.sv */
/* tb: good load, bad signatures, stalled reload.
   assumes srpl_loader, the ROM model and the monitor. */
`default_nettype none
module tb_serial_rom_register_preload;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 0, i_rst_b = 0, i_avs_read = 0, i_avs_write = 0;
    logic rv, rr, st, ft, cv, lb, wq, stall = 0, stall_en = 0;
    logic [7:0] rd, x = 0;
    logic [4:0] i_avs_address = 0;
    logic [31:0] wd = 0, rq, q, e;
    int mismatches = 0, num_checks = 0;
    srpl_loader dut (.i_clk_sys, .i_rst_b, .i_clk_en(1'b1), .i_rom_valid(rv),
        .i_rom_data(rd), .o_rom_ready(rr), .o_rom_start(st), .o_rom_fetch(ft),
        .o_cfg_valid(cv), .o_load_busy(lb), .i_avs_address, .i_avs_read,
        .i_avs_write, .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rq), .o_avs_waitrequest(wq));
    srpl_rom_model rom (.i_clk_sys, .i_rst_b, .i_start(st), .i_fetch(ft),
        .i_ready(rr), .i_stall(stall), .o_valid(rv), .o_data(rd));
    initial forever #10 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) stall <= stall_en & ~stall;
    function automatic logic [7:0] p(input int i);
        return 8'hF0 ^ i[7:0] ^ x;
    endfunction
    task automatic fill(input logic [7:0] b0);
        for (int i = 0; i < 67; i++) rom.img[i] = (i < 4) ? 8'h00 : p(i);
        rom.img[0] = b0;
    endtask
    task automatic chk(string n, logic [31:0] ex, logic [31:0] g);
        num_checks++;
        if (g !== ex) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, ex, g);
        end
    endtask
    task automatic av(logic w, logic [4:0] a, logic [31:0] d);
        @(posedge i_clk_sys);
        i_avs_read <= !w;
        i_avs_write <= w;
        i_avs_address <= a;
        wd <= d;
        do @(posedge i_clk_sys); while (wq !== 1'b0);
        q = rq;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    task automatic rdc(string n, logic [4:0] a, logic [31:0] ex);
        av(1'b0, a, 32'h0);
        chk(n, ex, a == 5'h01 ? {29'h0, q[2:0]} : q);
    endtask
    task automatic done;
        repeat (4) @(posedge i_clk_sys);
        do @(posedge i_clk_sys); while (cv !== 1'b1);
    endtask
    task automatic t_load;
        logic [7:0] b;
        b = p(38);
        rdc("pclass", 5'h02, {8'h0, p(6), p(5), p(4)});
        rdc("subsys", 5'h03, {p(10), p(9), p(8), p(7)});
        rdc("pgl", 5'h04, {16'h0, p(12), p(11)});
        rdc("sclass", 5'h05, {8'h0, p(15), p(14), p(13)});
        rdc("sgl", 5'h06, {16'h0, p(17), p(16)});
        rdc("dsm2", 5'h09, {p(29),p(28),p(27)&8'hF0,p(26)&8'h0E});
        rdc("dsm3", 5'h0A, {p(33),p(32),p(31)&8'hF0,p(30)&8'h0E});
        rdc("dsm3u", 5'h0B, {p(37), p(36), p(35), p(34)});
        rdc("usio0", 5'h0D, {p(43), p(42), p(41), p(40) & 8'hCF});
        rdc("usm1", 5'h0E, {p(47),p(46),p(45)&8'hF0,p(44)&8'h0E});
        rdc("arb", 5'h10, {16'h0, p(53) & 8'h03, p(52)});
        rdc("serr", 5'h11, {16'h0, p(55) & 8'h7F, p(54) & 8'h7F});
        rdc("dsm0", 5'h07, {p(21), p(20), p(19) & 8'hF0, p(18) & 8'h0E});
        rdc("dsio1", 5'h08, {p(25), p(24), p(23), p(22) & 8'hCF});
        rdc("xrom", 5'h0C, {7'h0, b[0], p(39), b[7:4], 12'h0});
        rdc("cc", 5'h0F, {p(51), p(50), p(49) & 8'hCF, p(48)});
        rdc("pmlo", 5'h12, {p(59), p(58), p(57), p(56)});
        rdc("unmap", 5'h1F, 32'h0);
        $display("t_load over");
    endtask
    task automatic t_bad;
        e = {8'h0, p(6), p(5), p(4)};
        x = 8'hFF;
        for (int k = 0; k < 4; k += k + 1) begin
            fill({k[1:0], 6'h00});
            av(1'b1, 5'h00, 32'h1);
            done;
            rdc("keep", 5'h02, e);
            rdc("sig", 5'h01, 32'h2);
        end
        $display("t_bad over");
    endtask
    task automatic t_stall;
        stall_en <= 1'b1;
        x = 8'h3C;
        fill(8'h80);
        av(1'b1, 5'h00, 32'h1);
        done;
        rdc("pclass2", 5'h02, {8'h0, p(6), p(5), p(4)});
        rdc("pmhi", 5'h13, {p(63), p(62), p(61), p(60)});
        rdc("cap", 5'h14, {16'h0, p(66), p(65) & 8'hFC});
        rdc("sig2", 5'h01, 32'h6);
        stall_en <= 1'b0;
        $display("t_stall over");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        fill(8'h80);
        repeat (8) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        done;
        t_load;
        t_bad;
        t_stall;
        close_out;
    end
    initial begin
        #400000;
        mismatches++;
        close_out;
    end
endmodule
bind srpl_loader srpl_monitor mon (.i_clk_sys, .i_rst_b, .i_avs_read,
    .i_avs_write, .o_avs_waitrequest, .o_rom_start, .o_rom_fetch,
    .o_cfg_valid, .o_load_busy, .o_rom_ready);
`default_nettype wire
